// ---- qpi_cmd.sv ----
// Command interpreter for quad-command mode, read parameters, wrapped reads and software reset
//
// Contract
// RULE_01 - In quad-command mode, C0h sets dummy clocks and wrap length.
// RULE_02 - C0h is ignored in serial mode; serial read dummies stay fixed.
// RULE_03 - Serial 77h sets wrap length from burst wrap length field; kept on entering quad mode.
// RULE_04 - Power-up or soft reset: 8-byte wrap, two dummy clocks.
// RULE_05 - Dummy select 00/01/10/11 gives 2/4/6/8 clocks.
// RULE_06 - Wrap select 00/01/10/11 gives 8/16/32/64 bytes.
// RULE_07 - 0Ch reads like quad fast read but wraps inside aligned window.
// RULE_08 - Exactly one mode at a time; only 38h enters quad mode.
// RULE_09 - Power-up starts in serial mode.
// RULE_10 - 38h is ignored while the quad enable bit is zero.
// RULE_11 - FFh in quad mode returns to serial mode.
// RULE_12 - Mode switches keep write enable latch and wrap length.
// RULE_13 - Soft reset restores power-on state and clears volatile settings.
// RULE_14 - 99h resets only directly after 66h; anything else disarms.
// RULE_15 - 66h and 99h work in both modes.
// RULE_16 - Commands ignored for about 30 us after an accepted reset.
// RULE_17 - Host should check write-in-progress before sending reset pair.
// RULE_18 - Host waits power-up write delay before any write instruction.
// RULE_19 - Host holds select high after supply reaches minimum.
// RULE_20 - Power-up also clears the armed reset state.
//
// The Avalon-MM interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module qpi_cmd (
  input wire logic i_mclk, // System clock, 50 MHz
  input wire logic i_rst, // Synchronous reset, active high
  input wire logic i_ce, // Clock enable, freezes all state when low
  input wire qpi_pkg::link_pins_t i_pins, // Chip select, serial clock, io inputs
  output logic [3:0] o_io, // io output data
  output logic [3:0] o_io_oe_n, // io output enable, low while driving
  input wire qpi_pkg::avs_req_t i_avs, // Avalon-MM request
  output qpi_pkg::avs_rsp_t o_avs // Avalon-MM response
);
  import qpi_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    phase_t phase;
    logic sclk_d;
    logic cs_d;
    logic [31:0] sh;
    logic [3:0] cnt;
    logic [7:0] op;
    logic op_ok;
    logic quad;
    logic write_enable_latch;
    logic armed;
    logic [1:0] dummy_sel;
    logic [1:0] wrap_sel;
    logic [2:0] wrap_bits;
    logic [7:0] mode_bits;
    logic [BUSY_W-1:0] busy;
    logic [23:0] addr;
    logic nib_hi;
    logic wrap_rd;
    logic [3:0] io_out;
    logic io_drv;
    logic ack;
    logic [31:0] rdata;
    logic quad_enable_bit;
    logic [7:0] pattern;
  } st_t;

  localparam st_t ST_RESET = '{
    phase: PH_IDLE,
    sclk_d: 1'b0,
    cs_d: 1'b1,
    sh: 32'h0000_0000,
    cnt: 4'h0,
    op: 8'h00,
    op_ok: 1'b0,
    quad: 1'b0,
    write_enable_latch: 1'b0,
    armed: 1'b0,
    dummy_sel: DUMMY_SEL_RESET,
    wrap_sel: WRAP_SEL_RESET,
    wrap_bits: WRAP_BITS_RESET,
    mode_bits: MODE_BITS_RESET,
    busy: '0,
    addr: 24'h00_0000,
    nib_hi: 1'b1,
    wrap_rd: 1'b0,
    io_out: 4'h0,
    io_drv: 1'b0,
    ack: 1'b0,
    rdata: 32'h0000_0000,
    quad_enable_bit: 1'b0,
    pattern: PATTERN_RESET
  };

  st_t st_reg;
  st_t st_next;
  link_pins_t pins_s;
  logic [23:0] addr_next;
  logic rise;
  logic fall;
  logic frame_start;
  logic frame_end;
  logic [31:0] sh_in;
  logic [3:0] cnt_inc;
  logic [7:0] data_byte;
  logic [31:0] status_word;
  logic [31:0] config_word;
  logic req;

  ////////////////////////////////////////////////////////////////////////////////
  // Pins come from the host's domain, so they pass two flops first
  pin_sync u_sync (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_d(i_pins),
    .o_q(pins_s)
  );

  // Burst address stepping, wrapped only for the wrap read
  wrap_addr u_wrap (
    .i_addr(st_reg.addr),
    .i_wrap(st_reg.wrap_rd), // [RULE_07]
    .i_wrap_sel(st_reg.wrap_sel), // [RULE_06]
    .o_next(addr_next)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Edge detection and shift input; quad mode and 77h frames take a nibble per clock
  always_comb begin
    rise = pins_s.sclk & ~st_reg.sclk_d;
    fall = ~pins_s.sclk & st_reg.sclk_d;
    frame_start = ~pins_s.cs_n & st_reg.cs_d;
    frame_end = pins_s.cs_n & ~st_reg.cs_d;
    cnt_inc = st_reg.cnt + 4'h1;
    if (st_reg.quad || st_reg.phase == PH_WRAPCFG) begin
      sh_in = {st_reg.sh[27:0], pins_s.io};
    end else begin
      sh_in = {st_reg.sh[30:0], pins_s.io[0]};
    end
    // No array behind this block: read data is address mixed with a pattern
    data_byte = st_reg.addr[7:0] ^ st_reg.pattern;
    req = i_avs.read | i_avs.write;
  end

  // Register read words
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[STS_QUAD_MODE] = st_reg.quad;
    status_word[STS_WRITE_LATCH] = st_reg.write_enable_latch;
    status_word[STS_ARMED] = st_reg.armed;
    status_word[STS_BUSY] = (st_reg.busy != '0);
    status_word[STS_DUMMY_SEL +: 2] = st_reg.dummy_sel;
    status_word[STS_WRAP_SEL +: 2] = st_reg.wrap_sel;
    status_word[STS_WRAP_BITS +: 3] = st_reg.wrap_bits;
    status_word[STS_MODE_BITS +: 8] = st_reg.mode_bits;
    config_word = 32'h0000_0000;
    config_word[CFG_QUAD_ENABLE] = st_reg.quad_enable_bit;
    config_word[CFG_PATTERN +: 8] = st_reg.pattern;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    st_next = st_reg;
    st_next.sclk_d = pins_s.sclk;
    st_next.cs_d = pins_s.cs_n;

    // Recovery countdown after an accepted reset
    if (st_reg.busy != '0) begin
      st_next.busy = st_reg.busy - BUSY_W'(1); // [RULE_16]
    end

    if (frame_end) begin
      // Frame closes: release io and execute single-byte commands
      st_next.phase = PH_IDLE;
      st_next.io_drv = 1'b0;
      st_next.cnt = 4'h0;
      st_next.op_ok = 1'b0;
      if (st_reg.op_ok) begin
        st_next.armed = (st_reg.op == OP_RESET_ENABLE); // [RULE_14] [RULE_15]
        case (st_reg.op)
          OP_ENABLE_QUAD_CMD: begin
            // Only entry to quad mode; write latch and wrap are left alone
            if (!st_reg.quad && st_reg.quad_enable_bit) begin
              st_next.quad = 1'b1; // [RULE_08] [RULE_10] [RULE_12]
            end
          end
          OP_DISABLE_QUAD_CMD: begin
            if (st_reg.quad) begin
              st_next.quad = 1'b0; // [RULE_11] [RULE_12]
            end
          end
          OP_WRITE_ENABLE: begin
            st_next.write_enable_latch = 1'b1;
          end
          OP_WRITE_DISABLE: begin
            st_next.write_enable_latch = 1'b0;
          end
          OP_RESET: begin
            if (st_reg.armed) begin
              // Back to power-on state; quad enable is non-volatile and kept
              st_next.quad = 1'b0; // [RULE_13]
              st_next.write_enable_latch = 1'b0; // [RULE_13]
              st_next.armed = 1'b0;
              st_next.dummy_sel = DUMMY_SEL_RESET; // [RULE_04] [RULE_13]
              st_next.wrap_sel = WRAP_SEL_RESET; // [RULE_04] [RULE_13]
              st_next.wrap_bits = WRAP_BITS_RESET; // [RULE_13]
              st_next.mode_bits = MODE_BITS_RESET; // [RULE_13]
              st_next.busy = BUSY_W'(RESET_RECOVERY_CYC); // [RULE_16]
            end
          end
          default: begin
          end
        endcase
      end
    end else if (pins_s.cs_n) begin
      st_next.phase = PH_IDLE;
      st_next.io_drv = 1'b0;
    end else if (frame_start) begin
      // Frames opened during recovery are swallowed whole
      st_next.phase = (st_reg.busy != '0) ? PH_IGNORE : PH_OPCODE; // [RULE_16]
      st_next.cnt = 4'h0;
      st_next.op_ok = 1'b0;
      st_next.io_drv = 1'b0;
    end else if (rise) begin
      st_next.sh = sh_in;
      st_next.cnt = cnt_inc;
      case (st_reg.phase)
        PH_OPCODE: begin
          if (cnt_inc == (st_reg.quad ? OPCODE_CLKS_QUAD : OPCODE_CLKS_SERIAL)) begin
            st_next.op = sh_in[7:0];
            st_next.op_ok = 1'b1;
            st_next.cnt = 4'h0;
            st_next.phase = PH_IGNORE;
            case (sh_in[7:0])
              OP_SET_READ_PARAM: begin
                // Serial mode refuses it; serial read dummies are not touched
                if (st_reg.quad) begin
                  st_next.phase = PH_PARAM; // [RULE_01] [RULE_02]
                end
              end
              OP_SET_BURST_WRAP: begin
                if (!st_reg.quad) begin
                  st_next.phase = PH_WRAPCFG; // [RULE_03]
                end
              end
              OP_FAST_READ, OP_QUAD_IO_READ: begin
                // Serial-mode reads belong to another block
                if (st_reg.quad) begin
                  st_next.phase = PH_ADDR;
                  st_next.wrap_rd = 1'b0;
                end
              end
              OP_BURST_WRAP_READ: begin
                if (st_reg.quad) begin
                  st_next.phase = PH_ADDR; // [RULE_07]
                  st_next.wrap_rd = 1'b1;
                end
              end
              default: begin
              end
            endcase
          end
        end
        PH_PARAM: begin
          if (cnt_inc == PARAM_CLKS) begin
            st_next.dummy_sel = sh_in[5:4]; // [RULE_01] [RULE_05]
            st_next.wrap_sel = sh_in[1:0]; // [RULE_01] [RULE_06]
            st_next.phase = PH_IGNORE;
          end
        end
        PH_WRAPCFG: begin
          // Six dummy nibbles, then the wrap byte on the last two clocks
          if (cnt_inc == WRAPCFG_CLKS) begin
            st_next.wrap_bits = sh_in[6:4];
            st_next.wrap_sel = sh_in[5:4]; // [RULE_03]
            st_next.phase = PH_IGNORE;
          end
        end
        PH_ADDR: begin
          if (cnt_inc == ADDR_CLKS) begin
            st_next.addr = sh_in[23:0];
            st_next.cnt = 4'h0;
            st_next.phase = PH_DUMMY;
          end
        end
        PH_DUMMY: begin
          // Quad I/O read carries its mode byte in the first two dummy clocks
          if (st_reg.op == OP_QUAD_IO_READ && cnt_inc == MODE_CLKS) begin
            st_next.mode_bits = sh_in[7:0];
          end
          if (cnt_inc == dummy_clocks(st_reg.dummy_sel)) begin
            st_next.phase = PH_DATA; // [RULE_01] [RULE_05]
            st_next.nib_hi = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end else if (fall && st_reg.phase == PH_DATA) begin
      // Data change on the falling edge, high nibble first
      st_next.io_drv = 1'b1;
      st_next.io_out = st_reg.nib_hi ? data_byte[7:4] : data_byte[3:0];
      st_next.nib_hi = ~st_reg.nib_hi;
      if (!st_reg.nib_hi) begin
        st_next.addr = addr_next; // [RULE_07]
      end
    end

    // Avalon slave: one wait cycle, then the answer with waitrequest low
    st_next.ack = req & ~st_reg.ack;
    if (req && !st_reg.ack) begin
      case (i_avs.address)
        REG_STATUS: begin
          st_next.rdata = status_word;
        end
        REG_CONFIG: begin
          st_next.rdata = config_word;
        end
        default: begin
          st_next.rdata = 32'h0000_0000;
        end
      endcase
    end
    if (i_avs.write && st_reg.ack && i_avs.address == REG_CONFIG) begin
      st_next.quad_enable_bit = i_avs.writedata[CFG_QUAD_ENABLE]; // [RULE_10]
      st_next.pattern = i_avs.writedata[CFG_PATTERN +: 8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register; power-up lands in serial mode with nothing armed
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      st_reg <= ST_RESET; // [RULE_04] [RULE_09] [RULE_20]
    end else if (i_ce) begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign o_io = st_reg.io_out;
  assign o_io_oe_n = {4{~st_reg.io_drv}};
  assign o_avs.waitrequest = req & ~st_reg.ack;
  assign o_avs.readdata = st_reg.rdata;

endmodule : qpi_cmd

`default_nettype wire

// ---- qpi_pkg.sv ----
// Shared constants, opcodes, register map and carrier types for the quad-command interpreter
`default_nettype none

package qpi_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned RESET_RECOVERY_NS = 30_000;
  // Least time, so rounded up to whole cycles
  localparam int unsigned RESET_RECOVERY_CYC = (RESET_RECOVERY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned BUSY_W = 11;

  ////////////////////////////////////////////////////////////////////////////////
  // Instruction codes
  localparam logic [7:0] OP_SET_READ_PARAM = 8'hC0;
  localparam logic [7:0] OP_SET_BURST_WRAP = 8'h77;
  localparam logic [7:0] OP_FAST_READ = 8'h0B;
  localparam logic [7:0] OP_QUAD_IO_READ = 8'hEB;
  localparam logic [7:0] OP_BURST_WRAP_READ = 8'h0C;
  localparam logic [7:0] OP_ENABLE_QUAD_CMD = 8'h38;
  localparam logic [7:0] OP_DISABLE_QUAD_CMD = 8'hFF;
  localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
  localparam logic [7:0] OP_RESET = 8'h99;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;

  ////////////////////////////////////////////////////////////////////////////////
  // Frame lengths in serial-clock edges
  localparam logic [3:0] OPCODE_CLKS_SERIAL = 4'h8;
  localparam logic [3:0] OPCODE_CLKS_QUAD = 4'h2;
  localparam logic [3:0] PARAM_CLKS = 4'h2;
  localparam logic [3:0] WRAPCFG_CLKS = 4'h8;
  localparam logic [3:0] ADDR_CLKS = 4'h6;
  localparam logic [3:0] MODE_CLKS = 4'h2;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values of the volatile settings
  localparam logic [1:0] DUMMY_SEL_RESET = 2'h0;
  localparam logic [1:0] WRAP_SEL_RESET = 2'h0;
  localparam logic [2:0] WRAP_BITS_RESET = 3'h0;
  localparam logic [7:0] MODE_BITS_RESET = 8'h00;
  localparam logic [7:0] PATTERN_RESET = 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses) and field positions
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_CONFIG = 4'h4;
  localparam int unsigned STS_QUAD_MODE = 0;
  localparam int unsigned STS_WRITE_LATCH = 1;
  localparam int unsigned STS_ARMED = 2;
  localparam int unsigned STS_BUSY = 3;
  localparam int unsigned STS_DUMMY_SEL = 4;
  localparam int unsigned STS_WRAP_SEL = 6;
  localparam int unsigned STS_WRAP_BITS = 8;
  localparam int unsigned STS_MODE_BITS = 16;
  localparam int unsigned CFG_QUAD_ENABLE = 0;
  localparam int unsigned CFG_PATTERN = 8;

  ////////////////////////////////////////////////////////////////////////////////
  // Carrier types
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic [3:0] io;
  } link_pins_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [31:0] writedata;
  } avs_req_t;

  typedef struct packed {
    logic waitrequest;
    logic [31:0] readdata;
  } avs_rsp_t;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_IGNORE,
    PH_OPCODE,
    PH_PARAM,
    PH_WRAPCFG,
    PH_ADDR,
    PH_DUMMY,
    PH_DATA
  } phase_t;

  // Dummy clocks per select code: 2, 4, 6, 8
  function automatic logic [3:0] dummy_clocks(input logic [1:0] sel);
    dummy_clocks = {1'b0, sel, 1'b0} + 4'h2;
  endfunction : dummy_clocks

endpackage : qpi_pkg

`default_nettype wire

// ---- pin_sync.sv ----
// Two-stage synchroniser for the link pins
`timescale 1ns/1ps
`default_nettype none

module pin_sync (
  input wire logic i_mclk, // System clock
  input wire logic i_rst, // Synchronous reset, active high
  input wire logic i_ce, // Clock enable
  input wire qpi_pkg::link_pins_t i_d, // Raw pins
  output qpi_pkg::link_pins_t o_q // Synchronised pins
);
  import qpi_pkg::*;

  typedef struct packed {
    link_pins_t s1;
    link_pins_t s2;
  } sync_st_t;

  localparam sync_st_t SYNC_RESET = '{s1: '{cs_n: 1'b1, sclk: 1'b0, io: 4'h0}, s2: '{cs_n: 1'b1, sclk: 1'b0, io: 4'h0}};

  sync_st_t sync_reg;
  sync_st_t sync_next;

  ////////////////////////////////////////////////////////////////////////////////
  // First stage feeds only the second; chip select idles high
  always_comb begin
    sync_next = sync_reg;
    sync_next.s1 = i_d;
    sync_next.s2 = sync_reg.s1;
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      sync_reg <= SYNC_RESET;
    end else if (i_ce) begin
      sync_reg <= sync_next;
    end
  end

  assign o_q = sync_reg.s2;

endmodule : pin_sync

`default_nettype wire

// ---- wrap_addr.sv ----
// Next-address logic for linear and wrapped bursts
`timescale 1ns/1ps
`default_nettype none

module wrap_addr (
  input wire logic [23:0] i_addr, // Current byte address
  input wire logic i_wrap, // Wrap inside aligned window
  input wire logic [1:0] i_wrap_sel, // Wrap length select
  output logic [23:0] o_next // Following address
);
  logic [5:0] mask;
  logic [5:0] low_inc;

  ////////////////////////////////////////////////////////////////////////////////
  // Window mask 7, 15, 31, 63 for 8, 16, 32, 64 bytes
  always_comb begin
    mask = 6'((7'h08 << i_wrap_sel) - 7'h01);
    low_inc = i_addr[5:0] + 6'h01;
    if (i_wrap) begin
      o_next = {i_addr[23:6], (i_addr[5:0] & ~mask) | (low_inc & mask)};
    end else begin
      o_next = i_addr + 24'h00_0001;
    end
  end

endmodule : wrap_addr

`default_nettype wire

// ---- qpi_cmd_monitor.sv ----
// Port-level checker for the quad-command interpreter
`timescale 1ns/1ps
`default_nettype none

module qpi_cmd_monitor (
  input wire logic i_mclk, // System clock
  input wire logic i_rst, // Synchronous reset
  input wire logic i_ce, // Clock enable
  input wire qpi_pkg::link_pins_t i_pins, // Link pins
  input wire logic [3:0] o_io, // io output data
  input wire logic [3:0] o_io_oe_n, // io output enable
  input wire qpi_pkg::avs_req_t i_avs, // Bus request
  input wire qpi_pkg::avs_rsp_t o_avs // Bus response
);
  import qpi_pkg::*;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  ////////////////////////////////////////////////////////////////////////////////
  // Rising pin clocks since select fell; pin edges lead the design's own count
  logic sclk_d;
  logic [7:0] rises;
  always_ff @(posedge i_mclk) begin
    sclk_d <= i_pins.sclk;
    if (i_rst || i_pins.cs_n) rises <= 8'h00;
    else if (i_pins.sclk && !sclk_d && rises != 8'hFF) rises <= rises + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus handshake
  AST_WAIT_FIRST: assert property ($rose(i_avs.read || i_avs.write) |-> o_avs.waitrequest)
    else $error("no wait state on new request");
  AST_WAIT_ONE: assert property ((i_avs.read || i_avs.write) && o_avs.waitrequest |=> !o_avs.waitrequest)
    else $error("more than one wait state");
  AST_IDLE_NO_WAIT: assert property (!(i_avs.read || i_avs.write) |-> !o_avs.waitrequest)
    else $error("waitrequest without request");
  AST_READ_HOLD: assert property (!(i_avs.read || i_avs.write) |=> $stable(o_avs.readdata))
    else $error("readdata moved without request");
  AST_UNMAPPED_ZERO: assert property (i_avs.read && !o_avs.waitrequest && i_avs.address != REG_STATUS
      && i_avs.address != REG_CONFIG |-> o_avs.readdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  ////////////////////////////////////////////////////////////////////////////////
  // Link outputs
  AST_RESET_QUIET: assert property ($fell(i_rst) |-> o_io_oe_n == 4'hF && o_io == 4'h0)
    else $error("outputs not quiet after reset");
  AST_OE_ALL_OR_NONE: assert property (o_io_oe_n == 4'h0 || o_io_oe_n == 4'hF)
    else $error("partial io drive");
  AST_OE_OFF_IDLE: assert property (i_pins.cs_n [*6] |-> o_io_oe_n == 4'hF)
    else $error("io driven outside a frame");
  AST_DRIVE_AFTER_MIN: assert property ($fell(o_io_oe_n[0]) |-> !i_pins.cs_n && rises >= 8'h0A)
    else $error("io driven before opcode, address and dummies");
  AST_IO_QUIET_IDLE: assert property (!i_pins.sclk [*7] |=> $stable(o_io))
    else $error("io data changed with clock standing");
endmodule : qpi_cmd_monitor

bind qpi_cmd qpi_cmd_monitor u_mon (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(i_ce), .i_pins(i_pins),
  .o_io(o_io), .o_io_oe_n(o_io_oe_n), .i_avs(i_avs), .o_avs(o_avs));

`default_nettype wire

// ---- link_host.sv ----
// Behavioural host controller that frames commands on the link pins
`timescale 1ns/1ps
`default_nettype none

module link_host #(
  parameter int SEL_CYC = 500, // Supply to select delay, 10 us
  parameter int WR_CYC = 500_000 // Power-up write delay
) (
  input wire logic i_mclk, // System clock
  input wire logic [3:0] i_io, // Resolved io wire level
  output logic o_cs_n, // Chip select
  output logic o_sclk, // Serial clock, still outside frames
  output logic [3:0] o_io // Host io drive
);
  logic [3:0] tx [16];
  logic [3:0] rx [16];
  int n_tx;
  int n_rx;
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_io = 4'h0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Timing helpers; 4 cycles low plus 4 high gives the 160 ns link clock
  task automatic wait_n(input int n);
    repeat (n) @(posedge i_mclk);
  endtask : wait_n
  task automatic power_up();
    wait_n(SEL_CYC);
    wait_n(WR_CYC);
  endtask : power_up
  // Released lines toggle so a stale value is never mistaken for data
  task automatic tick(input logic [3:0] d, input bit rel, output logic [3:0] q);
    o_sclk <= 1'b0;
    o_io <= rel ? ~o_io : d;
    wait_n(4);
    o_sclk <= 1'b1;
    wait_n(4);
    q = i_io;
  endtask : tick

  ////////////////////////////////////////////////////////////////////////////////
  // One frame: opcode, n_tx nibbles sent, n_rx nibbles received
  task automatic frame(input bit quad, input logic [7:0] op);
    logic [3:0] q;
    int i;
    o_cs_n <= 1'b0;
    wait_n(4);
    if (quad) begin
      tick(op[7:4], 1'b0, q);
      tick(op[3:0], 1'b0, q);
    end else begin
      for (i = 7; i >= 0; i--) tick({3'b000, op[i]}, 1'b0, q);
    end
    for (i = 0; i < n_tx; i++) tick(tx[i], 1'b0, q);
    for (i = 0; i < n_rx; i++) begin
      tick(4'h0, 1'b1, q);
      rx[i] = q;
    end
    o_sclk <= 1'b0;
    wait_n(4);
    o_cs_n <= 1'b1;
    o_io <= ~o_io;
    wait_n(8);
  endtask : frame
endmodule : link_host

`default_nettype wire

// ---- qpi_cmd_bench.sv ----
// Self-checking bench for the quad-command interpreter
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end

module qpi_cmd_bench;
  import qpi_pkg::*;
  localparam logic [31:0] QM = 32'h0000_0001 << STS_QUAD_MODE;
  localparam logic [31:0] WL = 32'h0000_0001 << STS_WRITE_LATCH;
  localparam logic [31:0] ARM = 32'h0000_0001 << STS_ARMED;
  localparam logic [31:0] BSY = 32'h0000_0001 << STS_BUSY;
  logic i_mclk = 1'b0;
  logic i_rst;
  logic cs_n;
  logic sclk;
  logic [3:0] io_h;
  logic [3:0] io_w;
  logic [3:0] o_io;
  logic [3:0] o_io_oe_n;
  link_pins_t pins;
  avs_req_t req;
  avs_rsp_t rsp;
  int fails = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [31:0] q;
  logic [23:0] a;
  logic [7:0] p;
  int k;
  int i;
  int n;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, wire resolution and instances
  always #10 i_mclk = ~i_mclk;
  assign io_w = (o_io & ~o_io_oe_n) | (io_h & o_io_oe_n);
  assign pins = {cs_n, sclk, io_w};
  qpi_cmd u_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(1'b1), .i_pins(pins), .o_io(o_io),
    .o_io_oe_n(o_io_oe_n), .i_avs(req), .o_avs(rsp));
  link_host #(.SEL_CYC(500), .WR_CYC(50_000)) u_host (.i_mclk(i_mclk), .i_io(io_w), .o_cs_n(cs_n),
    .o_sclk(sclk), .o_io(io_h));

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and hang guard; the ceiling covers power-up, two recoveries and all frames
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 75000) begin
      fails++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus cycle held until waitrequest is seen low, then released
  task automatic av(input logic w, input logic [3:0] ad, input logic [31:0] d, output logic [31:0] r);
    @(posedge i_mclk);
    req <= '{read: ~w, write: w, address: ad, writedata: d};
    do @(posedge i_mclk); while (rsp.waitrequest !== 1'b0);
    r = rsp.readdata;
    req <= '0;
  endtask : av
  task automatic chk_sts(input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    av(1'b0, REG_STATUS, 32'h0000_0000, r);
    `CHK("status", e, r & m)
  endtask : chk_sts
  task automatic cmd(input bit quad, input logic [7:0] op, input int nt, input int nr);
    u_host.n_tx = nt;
    u_host.n_rx = nr;
    u_host.frame(quad, op);
  endtask : cmd
  // Polls busy with a bounded count of reads
  task automatic wait_idle();
    logic [31:0] r;
    int t;
    for (t = 0; t < 1000; t++) begin
      av(1'b0, REG_STATUS, 32'h0000_0000, r);
      if (r[STS_BUSY] === 1'b0) break;
    end
  endtask : wait_idle

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    i_rst = 1'b1;
    req = '0;
    repeat (6) @(posedge i_mclk);
    i_rst <= 1'b0;
    u_host.power_up();
    chk_sts(32'hFFFF_FFFF, 32'h0000_0000);
    av(1'b0, REG_CONFIG, 32'h0000_0000, q);
    `CHK("config", 32'h0000_0000, q)
    av(1'b0, 4'h8, 32'h0000_0000, q);
    `CHK("unmapped", 32'h0000_0000, q)
    av(1'b1, REG_STATUS, 32'hFFFF_FFFF, q);
    u_host.tx[0] = 4'hF;
    u_host.tx[1] = 4'hF;
    cmd(0, OP_SET_READ_PARAM, 2, 0);
    cmd(0, OP_ENABLE_QUAD_CMD, 0, 0);
    cmd(0, OP_DISABLE_QUAD_CMD, 0, 0);
    chk_sts(32'hFFFF_FFFF, 32'h0000_0000);
    $display("test defaults and refusals done");
    for (i = 0; i < 8; i++) u_host.tx[i] = (i == 6) ? 4'h6 : 4'h0;
    cmd(0, OP_SET_BURST_WRAP, 8, 0);
    cmd(0, OP_WRITE_ENABLE, 0, 0);
    av(1'b1, REG_CONFIG, 32'h0000_A501, q);
    av(1'b0, REG_CONFIG, 32'h0000_0000, q);
    `CHK("config", 32'h0000_A501, q)
    cmd(0, OP_ENABLE_QUAD_CMD, 0, 0);
    chk_sts(32'h0000_07FF, QM | WL | 32'h0000_0680);
    $display("test enter quad mode done");
    for (k = 0; k < 4; k++) begin
      p = {2'b00, k[1:0], 2'b00, k[1:0]};
      u_host.tx[0] = p[7:4];
      u_host.tx[1] = p[3:0];
      cmd(1, OP_SET_READ_PARAM, 2, 0);
      chk_sts(32'h0000_00F0, {24'h00_0000, k[1:0], k[1:0], 4'h0});
      a = 24'(32'h0000_1000 + (8 << k) - 1);
      for (i = 0; i < 6; i++) u_host.tx[i] = a[23 - 4 * i -: 4];
      n = 2 + 2 * k;
      cmd(1, OP_BURST_WRAP_READ, 6, n + 4);
      `CHK("wrap_byte0", a[7:0] ^ 8'hA5, {u_host.rx[n], u_host.rx[n + 1]})
      `CHK("wrap_byte1", 8'hA5, {u_host.rx[n + 2], u_host.rx[n + 3]})
    end
    u_host.tx[6] = 4'h5;
    u_host.tx[7] = 4'hA;
    cmd(1, OP_QUAD_IO_READ, 8, 10);
    `CHK("linear", 16'h9AE5, {u_host.rx[6], u_host.rx[7], u_host.rx[8], u_host.rx[9]})
    chk_sts(32'h00FF_0000, 32'h005A_0000);
    $display("test read parameters and wrapped reads done");
    cmd(1, OP_DISABLE_QUAD_CMD, 0, 0);
    chk_sts(32'h0000_00FF, WL | 32'h0000_00F0);
    cmd(0, OP_RESET_ENABLE, 0, 0);
    chk_sts(ARM, ARM);
    cmd(0, OP_WRITE_ENABLE, 0, 0);
    chk_sts(ARM, 32'h0000_0000);
    cmd(0, OP_RESET, 0, 0);
    chk_sts(32'h0000_00FF, WL | 32'h0000_00F0);
    chk_sts(BSY, 32'h0000_0000);
    cmd(0, OP_RESET_ENABLE, 0, 0);
    cmd(0, OP_RESET, 0, 0);
    chk_sts(32'h00FF_FFFF, BSY);
    cmd(0, OP_WRITE_ENABLE, 0, 0);
    wait_idle();
    chk_sts(32'hFFFF_FFFF, 32'h0000_0000);
    $display("test serial reset done");
    cmd(0, OP_ENABLE_QUAD_CMD, 0, 0);
    chk_sts(QM, QM);
    cmd(1, OP_RESET_ENABLE, 0, 0);
    cmd(1, OP_RESET, 0, 0);
    chk_sts(32'h00FF_FFFF, BSY);
    wait_idle();
    chk_sts(32'hFFFF_FFFF, 32'h0000_0000);
    $display("test quad reset done");
    complete_run();
  end
endmodule : qpi_cmd_bench

`default_nettype wire
